//--- src/itab_core.sv
// What this block does
// R1 - Trap instruction starts exception processing at any time during execution.
// R2 - Entry pushes PC and CONDITION_CODE_REGISTER, then loads handler address from vector table.
// R3 - Trap selects vector entry 0 to 3 from the instruction's number.
// R4 - After entry I is set; UI kept in mode 0, set in mode 1.
// R5 - Word and longword accesses force the lowest address bit to zero.
// R6 - Software keeps the stack pointer even and stacks only words or longs.
// R7 - Two control modes selected by a two-bit field in system control.
// R8 - Priority bit clear gives level 0, set gives level 1; reset zero.
// R9 - Nonmaskable request has top priority, always taken, ignores priority bits.
// R10 - Nonmaskable input detects rising or falling edge as selected.
// R11 - Eight maskable pins each detect falling, rising, both edges or level.
// R12 - Each maskable request comes from its primary or alternate pin.
// R13 - Every source owns a distinct vector address.
// R14 - Priority bits map to sources per the fixed three-register table.
// R15 - Software writes zero to unassigned priority bits.
// R16 - Address break requested only while match flag and break enable are 1.
// R17 - Match flag sets when break address is prefetched with enable 1.
// R18 - Match flag clears when address break exception processing runs.
// R19 - Break control bits 6 to 1 read zero and ignore writes.
// R20 - Break control bit 0 enables breaks; resets to zero.
// R21 - Break compare uses address bits 23 to 1; stored bit 0 reads zero.
// R22 - Sense field: 00 low level, 01 falling, 10 rising, 11 both edges.
// R23 - A maskable pin request is enabled only while its enable bit is 1.
// R24 - Equal-level pending requests are chosen lowest vector number first.
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none
module itab_core (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_nmi,
  input wire logic [7:0] i_pin,
  input wire logic [7:0] i_pin_alt,
  input wire logic [7:0] i_periph_req,
  input wire itab_pkg::itab_cpu_in_s i_cpu,
  output itab_pkg::itab_cpu_out_s o_cpu,
  output logic o_busy,
  output logic o_irq_pend,
  output logic o_break_req,
  output itab_pkg::itab_mem_s o_mem,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata
);
  typedef struct packed {
    logic [7:0] lvl_a;
    logic [7:0] lvl_b;
    logic [7:0] lvl_c;
    logic brk_en;
    logic match_flag;
    logic [23:1] brk_addr;
    logic [15:0] sense;
    logic [7:0] pin_en;
    logic [7:0] pin_flag;
    logic [7:0] port_sel;
    logic [1:0] mode;
    logic nmi_rise;
    logic [7:0] pin_prev;
    logic nmi_prev;
    logic nmi_flag;
    logic trap_pend;
    logic [1:0] trap_num;
    itab_pkg::itab_seq_e st;
    logic [7:0] ccr_save;
    logic [23:0] pc_save;
    itab_pkg::itab_cpu_out_s cpu;
    itab_pkg::itab_mem_s mem;
    logic [31:0] prdata;
    logic slverr;
  } itab_state_s;

  itab_state_s q;
  itab_state_s d;

  function automatic logic pin_event(input logic [1:0] sense, input logic prev,
                                     input logic now);
    case (sense)
      itab_pkg::SENSE_LOW: pin_event = ~now;
      itab_pkg::SENSE_FALL: pin_event = prev & ~now;
      itab_pkg::SENSE_RISE: pin_event = ~prev & now;
      default: pin_event = prev ^ now;
    endcase
  endfunction : pin_event

  function automatic logic [23:0] align_addr(input logic [23:0] a);
    align_addr = {a[23:1], 1'b0};
  endfunction : align_addr

  function automatic logic [7:0] src_vec(input int k);
    if (k < 8) begin
      src_vec = itab_pkg::VEC_PIN_BASE + 8'(k);
    end else if (k < itab_pkg::SRC_BREAK) begin
      src_vec = itab_pkg::VEC_PERIPH_BASE + 8'(k - 8);
    end else begin
      src_vec = itab_pkg::VEC_BREAK;
    end
  endfunction : src_vec

  logic [7:0] pin_now;
  logic [7:0] pin_hit;
  logic [itab_pkg::NSRC-1:0] src_req;
  logic [itab_pkg::NSRC-1:0] src_lvl;
  logic nmi_edge;
  logic mode1;
  logic ccr_i;
  logic ccr_ui;
  logic sel_valid;
  logic [4:0] sel_idx;
  logic [7:0] sel_vec;
  logic take_irq;
  logic take_trap;
  logic brk_hit;
  logic hit;
  logic wr;

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      pin_now[k] = q.port_sel[k] ? i_pin_alt[k] : i_pin[k]; // R12
      pin_hit[k] = pin_event(q.sense[2*k +: 2], q.pin_prev[k], pin_now[k]); // R11 R22
    end
  end

  assign nmi_edge = q.nmi_rise ? (~q.nmi_prev & i_nmi) : (q.nmi_prev & ~i_nmi); // R10
  assign mode1 = q.mode[1]; // R7
  assign ccr_i = i_cpu.condition_code_register[itab_pkg::CCR_I_BIT];
  assign ccr_ui = i_cpu.condition_code_register[itab_pkg::CCR_UI_BIT];
  assign brk_hit = q.brk_en & i_cpu.prefetch & (i_cpu.prefetch_addr[23:1] == q.brk_addr); // R17 R21

  always_comb begin
    src_req = '0;
    src_req[7:0] = q.pin_flag & q.pin_en; // R23
    src_req[15:8] = i_periph_req;
    src_req[itab_pkg::SRC_BREAK] = q.match_flag & q.brk_en; // R16
    src_lvl = '0; // R14
    src_lvl[0] = q.lvl_a[7];
    src_lvl[1] = q.lvl_a[6];
    src_lvl[3:2] = {2{q.lvl_a[5]}};
    src_lvl[5:4] = {2{q.lvl_a[4]}};
    src_lvl[7:6] = {2{q.lvl_a[3]}};
    src_lvl[8 + itab_pkg::PER_WATCHDOG] = q.lvl_a[1];
    src_lvl[8 + itab_pkg::PER_REFRESH] = q.lvl_a[0];
    src_lvl[8 + itab_pkg::PER_SUSPEND] = q.lvl_b[6];
    src_lvl[8 + itab_pkg::PER_DMA] = q.lvl_b[5];
    src_lvl[8 + itab_pkg::PER_TIMER0] = q.lvl_b[3];
    src_lvl[8 + itab_pkg::PER_TIMER1] = q.lvl_b[2];
    src_lvl[8 + itab_pkg::PER_SERIAL] = q.lvl_c[7];
    src_lvl[8 + itab_pkg::PER_USB] = q.lvl_c[0];
  end

  // Level 1 first, then level 0, lowest index within a level
  always_comb begin
    logic ok1;
    logic ok0;
    ok1 = mode1 ? ~ccr_i : ~ccr_i;
    ok0 = mode1 ? (~ccr_i & ~ccr_ui) : ~ccr_i;
    sel_valid = 1'b0;
    sel_idx = 5'h00;
    sel_vec = 8'h00;
    if (q.nmi_flag) begin
      sel_valid = 1'b1; // R9
      sel_idx = 5'h1F;
      sel_vec = itab_pkg::VEC_NMI;
    end else begin
      for (int k = itab_pkg::NSRC - 1; k >= 0; k--) begin
        if (ok0 && src_req[k] && !src_lvl[k]) begin
          sel_valid = 1'b1; // R24
          sel_idx = 5'(k);
          sel_vec = src_vec(k); // R13
        end
      end
      for (int k = itab_pkg::NSRC - 1; k >= 0; k--) begin
        if (ok1 && src_req[k] && src_lvl[k]) begin
          sel_valid = 1'b1; // R8
          sel_idx = 5'(k);
          sel_vec = src_vec(k);
        end
      end
    end
  end

  assign take_irq = (q.st == itab_pkg::SEQ_IDLE) & i_cpu.boundary & sel_valid;
  assign take_trap = (q.st == itab_pkg::SEQ_IDLE) & ~take_irq & (i_cpu.trap_exec | q.trap_pend); // R1

  always_comb begin
    hit = (i_paddr[31:8] == 24'h000000) && (i_paddr[1:0] == 2'h0);
    case (i_paddr[7:0])
      itab_pkg::OFS_LVL_A, itab_pkg::OFS_LVL_B, itab_pkg::OFS_LVL_C,
      itab_pkg::OFS_BRK_CTRL, itab_pkg::OFS_BRK_UPPER, itab_pkg::OFS_BRK_MID,
      itab_pkg::OFS_BRK_LOWER, itab_pkg::OFS_SENSE_HI, itab_pkg::OFS_SENSE_LO,
      itab_pkg::OFS_PIN_EN, itab_pkg::OFS_PIN_FLAG, itab_pkg::OFS_PORT_SEL,
      itab_pkg::OFS_SYS_CTRL: hit = hit;
      default: hit = 1'b0;
    endcase
  end

  assign wr = i_psel & i_penable & i_pwrite & hit;

  always_comb begin
    logic [7:0] wb;
    logic [7:0] pin_clr;
    logic [7:0] pin_set;
    logic clr_match;
    logic clr_nmi;
    wb = i_pwdata[7:0];
    pin_clr = 8'h00;
    pin_set = 8'h00;
    clr_match = 1'b0;
    clr_nmi = 1'b0;
    d = q;
    d.cpu.pc_load = 1'b0;
    d.pin_prev = pin_now;
    d.nmi_prev = i_nmi;
    // Register writes take effect in the access phase
    if (wr) begin
      case (i_paddr[7:0])
        itab_pkg::OFS_LVL_A: d.lvl_a = wb & itab_pkg::LVL_A_MASK; // R8 R15
        itab_pkg::OFS_LVL_B: d.lvl_b = wb & itab_pkg::LVL_B_MASK;
        itab_pkg::OFS_LVL_C: d.lvl_c = wb & itab_pkg::LVL_C_MASK;
        itab_pkg::OFS_BRK_CTRL: begin
          d.brk_en = wb[itab_pkg::BRK_EN_BIT]; // R20
          clr_match = ~wb[itab_pkg::BRK_FLAG_BIT];
        end
        itab_pkg::OFS_BRK_UPPER: d.brk_addr[23:16] = wb;
        itab_pkg::OFS_BRK_MID: d.brk_addr[15:8] = wb;
        itab_pkg::OFS_BRK_LOWER: d.brk_addr[7:1] = wb[7:1]; // R21
        itab_pkg::OFS_SENSE_HI: d.sense[15:8] = wb;
        itab_pkg::OFS_SENSE_LO: d.sense[7:0] = wb;
        itab_pkg::OFS_PIN_EN: d.pin_en = wb;
        itab_pkg::OFS_PIN_FLAG: pin_clr = ~wb;
        itab_pkg::OFS_PORT_SEL: d.port_sel = wb;
        itab_pkg::OFS_SYS_CTRL: begin
          d.mode = i_pwdata[itab_pkg::MODE_LSB +: 2]; // R7
          d.nmi_rise = wb[itab_pkg::NMI_RISE_BIT];
        end
        default: d.mode = q.mode;
      endcase
    end
    // Read data captured in the setup phase
    if (i_psel && !i_penable) begin
      d.slverr = ~hit;
      d.prdata = 32'h00000000;
      if (hit) begin
        case (i_paddr[7:0])
          itab_pkg::OFS_LVL_A: d.prdata[7:0] = q.lvl_a;
          itab_pkg::OFS_LVL_B: d.prdata[7:0] = q.lvl_b;
          itab_pkg::OFS_LVL_C: d.prdata[7:0] = q.lvl_c;
          itab_pkg::OFS_BRK_CTRL: d.prdata[7:0] = {q.match_flag, 6'h00, q.brk_en}; // R19
          itab_pkg::OFS_BRK_UPPER: d.prdata[7:0] = q.brk_addr[23:16];
          itab_pkg::OFS_BRK_MID: d.prdata[7:0] = q.brk_addr[15:8];
          itab_pkg::OFS_BRK_LOWER: d.prdata[7:0] = {q.brk_addr[7:1], 1'b0};
          itab_pkg::OFS_SENSE_HI: d.prdata[7:0] = q.sense[15:8];
          itab_pkg::OFS_SENSE_LO: d.prdata[7:0] = q.sense[7:0];
          itab_pkg::OFS_PIN_EN: d.prdata[7:0] = q.pin_en;
          itab_pkg::OFS_PIN_FLAG: d.prdata[7:0] = q.pin_flag;
          itab_pkg::OFS_PORT_SEL: d.prdata[7:0] = q.port_sel;
          default: d.prdata[7:0] = {2'h0, q.mode, 3'h0, q.nmi_rise};
        endcase
      end
    end
    // Service start clears the source flag of an edge request
    if (take_irq) begin
      if (q.nmi_flag) begin
        clr_nmi = 1'b1;
      end else if (sel_idx == 5'(itab_pkg::SRC_BREAK)) begin
        clr_match = 1'b1; // R18
      end else if (sel_idx < 5'h08) begin
        pin_clr[sel_idx[2:0]] = 1'b1;
      end
    end
    for (int k = 0; k < 8; k++) begin
      if (q.sense[2*k +: 2] == itab_pkg::SENSE_LOW) begin
        pin_set[k] = pin_hit[k];
        pin_clr[k] = pin_clr[k] | ~pin_hit[k];
      end else begin
        pin_set[k] = pin_hit[k];
      end
    end
    // Set wins over clear
    d.pin_flag = (q.pin_flag & ~pin_clr) | pin_set;
    d.match_flag = (q.match_flag & ~clr_match) | brk_hit; // R17
    d.nmi_flag = (q.nmi_flag & ~clr_nmi) | nmi_edge; // R9
    if (i_cpu.trap_exec && !take_trap) begin
      d.trap_pend = 1'b1;
      d.trap_num = i_cpu.trap_num;
    end
    case (q.st)
      itab_pkg::SEQ_IDLE: begin
        if (take_irq || take_trap) begin
          d.st = itab_pkg::SEQ_PUSH;
          d.ccr_save = i_cpu.condition_code_register;
          d.pc_save = i_cpu.pc;
          d.mem.req = 1'b1;
          d.mem.we = 1'b1;
          d.mem.addr = align_addr(i_cpu.sp - itab_pkg::STACK_STEP); // R2 R5
          d.mem.wdata = {i_cpu.condition_code_register, i_cpu.pc};
          d.cpu.new_sp = align_addr(i_cpu.sp - itab_pkg::STACK_STEP);
          if (take_irq) begin
            d.cpu.vec = sel_vec;
          end else begin
            d.trap_pend = 1'b0;
            d.cpu.vec = itab_pkg::VEC_TRAP_BASE + {6'h00,
                        (q.trap_pend ? q.trap_num : i_cpu.trap_num)}; // R3
          end
        end
      end
      itab_pkg::SEQ_PUSH: begin
        if (i_mem_ack) begin
          d.st = itab_pkg::SEQ_FETCH; // R2
          d.mem.we = 1'b0;
          d.mem.addr = align_addr({14'h0000, q.cpu.vec, 2'h0}); // R5
        end
      end
      itab_pkg::SEQ_FETCH: begin
        if (i_mem_ack) begin
          d.st = itab_pkg::SEQ_IDLE;
          d.mem.req = 1'b0;
          d.cpu.pc_load = 1'b1;
          d.cpu.new_pc = i_mem_rdata[23:0];
          d.cpu.new_ccr = q.ccr_save;
          d.cpu.new_ccr[itab_pkg::CCR_I_BIT] = 1'b1; // R4
          d.cpu.new_ccr[itab_pkg::CCR_UI_BIT] = mode1 | q.ccr_save[itab_pkg::CCR_UI_BIT];
        end
      end
      default: d.st = itab_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      q <= '0; // R8 R20
      q.lvl_a <= itab_pkg::LVL_RESET;
      q.lvl_b <= itab_pkg::LVL_RESET;
      q.lvl_c <= itab_pkg::LVL_RESET;
      q.st <= itab_pkg::SEQ_IDLE;
      q.nmi_prev <= 1'b1;
      q.pin_prev <= 8'hFF;
    end else begin
      q <= d;
    end
  end

  assign o_prdata = q.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & q.slverr;
  assign o_cpu = q.cpu;
  assign o_mem = q.mem;
  assign o_busy = (q.st != itab_pkg::SEQ_IDLE);
  assign o_irq_pend = sel_valid;
  assign o_break_req = q.match_flag & q.brk_en; // R16

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  chk_break_set: assert property (brk_hit |=> q.match_flag) // R17
    else $error("match flag not set on break hit");
  chk_break_clear: assert property (take_irq && !q.nmi_flag && sel_idx == 5'h10 && !brk_hit
    |=> !q.match_flag) // R18
    else $error("match flag not cleared on break service");
  chk_trap_vec: assert property (take_trap && !q.trap_pend
    |=> q.cpu.vec == itab_pkg::VEC_TRAP_BASE + {6'h00, $past(i_cpu.trap_num)}) // R3
    else $error("wrong trap vector");
  chk_ccr_mask: assert property (q.cpu.pc_load |-> q.cpu.new_ccr[7]
    && (q.cpu.new_ccr[6] == (q.mode[1] | q.ccr_save[6]))) // R4
    else $error("wrong CONDITION_CODE_REGISTER after entry");
  chk_push_first: assert property ((take_irq || take_trap)
    |=> q.mem.req && q.mem.we && q.mem.addr == align_addr($past(i_cpu.sp) - 24'h000004)) // R2
    else $error("stack push not first");
  chk_align_addr: assert property (q.mem.req |-> !q.mem.addr[0]) // R5
    else $error("odd memory address");
  chk_nmi_first: assert property (take_irq && q.nmi_flag |=> q.cpu.vec == 8'h07) // R9
    else $error("nmi not taken first");
  chk_pin_enable: assert property (o_irq_pend && !q.nmi_flag && sel_idx < 5'h08
    |-> q.pin_en[sel_idx[2:0]]) // R23
    else $error("disabled pin request taken");
  chk_reserved_zero: assert property (i_psel && !i_penable && i_paddr == 32'h0000000C
    |=> o_prdata[6:1] == 6'h00) // R19
    else $error("reserved break bits not zero");
  chk_fetch_after_push: assert property (q.st == itab_pkg::SEQ_PUSH && i_mem_ack
    |=> q.mem.req && !q.mem.we && q.mem.addr == {14'h0000, q.cpu.vec, 2'h0}) // R2
    else $error("vector fetch wrong");

  cov_trap_entry: cover property (take_trap ##[1:20] q.cpu.pc_load);
  cov_nmi_entry: cover property (take_irq && q.nmi_flag ##[1:20] q.cpu.pc_load);
  cov_break_entry: cover property (brk_hit ##[1:50] (take_irq && sel_idx == 5'h10));
  cov_lvl1_win: cover property (take_irq && src_lvl[sel_idx[3:0]] && |(src_req & ~src_lvl));
endmodule : itab_core
`default_nettype wire

//--- src/itab_pkg.sv
package itab_pkg;
  // Byte offsets on the register bus
  localparam logic [7:0] OFS_LVL_A = 8'h00;
  localparam logic [7:0] OFS_LVL_B = 8'h04;
  localparam logic [7:0] OFS_LVL_C = 8'h08;
  localparam logic [7:0] OFS_BRK_CTRL = 8'h0C;
  localparam logic [7:0] OFS_BRK_UPPER = 8'h10;
  localparam logic [7:0] OFS_BRK_MID = 8'h14;
  localparam logic [7:0] OFS_BRK_LOWER = 8'h18;
  localparam logic [7:0] OFS_SENSE_HI = 8'h1C;
  localparam logic [7:0] OFS_SENSE_LO = 8'h20;
  localparam logic [7:0] OFS_PIN_EN = 8'h24;
  localparam logic [7:0] OFS_PIN_FLAG = 8'h28;
  localparam logic [7:0] OFS_PORT_SEL = 8'h2C;
  localparam logic [7:0] OFS_SYS_CTRL = 8'h30;
  // Implemented bits of the priority registers
  localparam logic [7:0] LVL_A_MASK = 8'hFB;
  localparam logic [7:0] LVL_B_MASK = 8'h6C;
  localparam logic [7:0] LVL_C_MASK = 8'h81;
  localparam logic [7:0] LVL_RESET = 8'h00;
  // Field positions
  localparam int BRK_FLAG_BIT = 7;
  localparam int BRK_EN_BIT = 0;
  localparam int MODE_LSB = 4;
  localparam int NMI_RISE_BIT = 0;
  localparam int CCR_I_BIT = 7;
  localparam int CCR_UI_BIT = 6;
  // Vector numbers
  localparam logic [7:0] VEC_NMI = 8'h07;
  localparam logic [7:0] VEC_TRAP_BASE = 8'h08;
  localparam logic [7:0] VEC_PIN_BASE = 8'h10;
  localparam logic [7:0] VEC_PERIPH_BASE = 8'h18;
  localparam logic [7:0] VEC_BREAK = 8'h20;
  localparam int NSRC = 17;
  localparam int SRC_BREAK = 16;
  // Peripheral request positions
  localparam int PER_WATCHDOG = 0;
  localparam int PER_REFRESH = 1;
  localparam int PER_SUSPEND = 2;
  localparam int PER_DMA = 3;
  localparam int PER_TIMER0 = 4;
  localparam int PER_TIMER1 = 5;
  localparam int PER_SERIAL = 6;
  localparam int PER_USB = 7;
  // Sense encodings
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_FALL = 2'h1;
  localparam logic [1:0] SENSE_RISE = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;
  localparam logic [23:0] STACK_STEP = 24'h000004;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_PUSH = 2'b01,
    SEQ_FETCH = 2'b10
  } itab_seq_e;

  typedef struct packed {
    logic boundary;
    logic trap_exec;
    logic [1:0] trap_num;
    logic [23:0] pc;
    logic [7:0] condition_code_register;
    logic [23:0] sp;
    logic prefetch;
    logic [23:0] prefetch_addr;
  } itab_cpu_in_s;

  typedef struct packed {
    logic pc_load;
    logic [23:0] new_pc;
    logic [7:0] new_ccr;
    logic [23:0] new_sp;
    logic [7:0] vec;
  } itab_cpu_out_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [23:0] addr;
    logic [31:0] wdata;
  } itab_mem_s;
endpackage : itab_pkg

//--- tb/itab_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module itab_mem_model (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire itab_pkg::itab_mem_s i_mem,
  output logic o_ack,
  output logic [31:0] o_rdata,
  output logic [23:0] o_waddr,
  output logic [31:0] o_wdata
);
  logic [1:0] wait_q;
  initial begin
    o_ack = 1'b0;
    o_rdata = 32'h0;
    o_waddr = 24'h0;
    o_wdata = 32'h0;
    wait_q = 2'h0;
  end
  // Answers at once or after two cycles; idle data bus toggles
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    wait_q <= 2'h0;
    if (i_mem.req && !o_ack) begin
      if (wait_q >= (i_slow ? 2'h2 : 2'h0)) begin
        o_ack <= 1'b1;
        if (i_mem.we) begin
          o_waddr <= i_mem.addr;
          o_wdata <= i_mem.wdata;
        end else begin
          o_rdata <= {8'h00, i_mem.addr ^ 24'h5A0000};
        end
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule : itab_mem_model
`default_nettype wire

//--- tb/tb_intc_trap_address_break.sv
`timescale 1ns/1ns
`default_nettype none
module tb_intc_trap_address_break;
  logic clk, srst, psel, pen, pwr, nmi, slow, pready, pslverr, busy, pend, brk, ack, err;
  logic [31:0] paddr, pwdata, rd, seed, prdata, mrd, mwd;
  logic [23:0] mwa, ba;
  logic [7:0] pin, alt, preq;
  logic [2:0] k;
  logic sa;
  itab_pkg::itab_cpu_in_s cpu;
  itab_pkg::itab_cpu_out_s cout;
  itab_pkg::itab_mem_s mem;
  int n_fail, n_tests;

  itab_core dut_u (.i_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_nmi(nmi), .i_pin(pin),
    .i_pin_alt(alt), .i_periph_req(preq), .i_cpu(cpu), .o_cpu(cout), .o_busy(busy),
    .o_irq_pend(pend), .o_break_req(brk), .o_mem(mem), .i_mem_ack(ack),
    .i_mem_rdata(mrd));
  itab_mem_model mem_u (.i_clk(clk), .i_slow(slow), .i_mem(mem), .o_ack(ack),
    .o_rdata(mrd), .o_waddr(mwa), .o_wdata(mwd));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic end_of_test();
    $display("counts: %0d compares, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic hang(input string what);
    n_tests++;
    n_fail++;
    $display("mismatch %s expected done seen timeout", what);
    end_of_test();
  endtask : hang

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) hang("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdc

  task automatic look(input string what, input logic exp);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(what, {31'h0, exp}, {31'h0, pend});
    @(posedge clk);
  endtask : look

  task automatic pf(input logic [23:0] a);
    @(posedge clk);
    cpu.prefetch <= 1'b1;
    cpu.prefetch_addr <= a;
    @(posedge clk);
    cpu.prefetch <= 1'b0;
    @(negedge clk);
  endtask : pf

  task automatic drv(input logic v);
    @(posedge clk);
    if (sa) alt[k] <= v;
    else pin[k] <= v;
  endtask : drv

  task automatic entry(input logic trap, input logic [1:0] n, input logic [7:0] ev,
    input logic m1);
    int i;
    logic [23:0] sp;
    seed = lfsr(seed);
    sp = {seed[23:1], 1'b0} - itab_pkg::STACK_STEP;
    @(posedge clk);
    cpu.boundary <= !trap;
    cpu.trap_exec <= trap;
    cpu.trap_num <= n;
    cpu.sp <= {seed[23:1], 1'b0};
    cpu.pc <= seed[31:8];
    slow <= seed[5];
    @(posedge clk);
    cpu.boundary <= 1'b0;
    cpu.trap_exec <= 1'b0;
    @(negedge clk);
    chk("busy_start", 32'h1, {31'h0, busy});
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (cout.pc_load !== 1'b1 && i < 40);
    if (i >= 40) hang("entry");
    chk("vec", {24'h0, ev}, {24'h0, cout.vec});
    chk("new_pc", {8'h0, {14'h0, ev, 2'h0} ^ 24'h5A0000}, {8'h0, cout.new_pc});
    chk("new_sp", {8'h0, sp}, {8'h0, cout.new_sp});
    chk("push_addr", {8'h0, sp[23:1], 1'b0}, {8'h0, mwa});
    chk("push_data", {cpu.condition_code_register, cpu.pc}, mwd);
    chk("new_ccr", {24'h0, 1'b1, m1 | cpu.condition_code_register[6], cpu.condition_code_register[5:0]}, {24'h0, cout.new_ccr});
    chk("busy_end", 32'h0, {31'h0, busy});
    @(posedge clk);
  endtask : entry

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    logic [7:0] msk [3];
    {psel, pen, pwr, slow, n_fail, n_tests} = '0;
    {paddr, pwdata, preq} = '0;
    cpu = '0;
    {nmi, srst} = 2'b11;
    {pin, alt} = 16'hFFFF;
    seed = 32'h565FE1E9;
    msk = '{itab_pkg::LVL_A_MASK, itab_pkg::LVL_B_MASK, itab_pkg::LVL_C_MASK};
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    for (int r = 0; r < 3; r++) begin
      rdc("lvl_reset", 8'(4 * r), 32'h0);
      seed = lfsr(seed);
      apb(1'b1, 8'(4 * r), {24'h0, seed[7:0] & msk[r]});
      rdc("lvl_rw", 8'(4 * r), {24'h0, seed[7:0] & msk[r]});
      apb(1'b1, 8'(4 * r), 32'h0);
    end
    rdc("brk_reset", itab_pkg::OFS_BRK_CTRL, 32'h0);
    apb(1'b1, itab_pkg::OFS_BRK_CTRL, 32'h7F);
    rdc("brk_ctrl", itab_pkg::OFS_BRK_CTRL, 32'h01);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("test registers done");
    seed = lfsr(seed);
    ba = seed[23:0];
    apb(1'b1, itab_pkg::OFS_BRK_UPPER, {24'h0, ba[23:16]});
    apb(1'b1, itab_pkg::OFS_BRK_MID, {24'h0, ba[15:8]});
    apb(1'b1, itab_pkg::OFS_BRK_LOWER, {24'h0, ba[7:0]});
    rdc("brk_lower", itab_pkg::OFS_BRK_LOWER, {24'h0, ba[7:1], 1'b0});
    pf(ba ^ 24'h000002);
    chk("brk_miss", 32'h0, {31'h0, brk});
    pf(ba ^ 24'h000001);
    chk("brk_hit", 32'h1, {31'h0, brk});
    apb(1'b1, itab_pkg::OFS_BRK_CTRL, 32'h80);
    @(negedge clk);
    chk("brk_off", 32'h0, {31'h0, brk});
    apb(1'b1, itab_pkg::OFS_BRK_CTRL, 32'h81);
    look("brk_pend", 1'b1);
    entry(1'b0, 2'h0, itab_pkg::VEC_BREAK, 1'b0);
    rdc("brk_clear", itab_pkg::OFS_BRK_CTRL, 32'h01);
    apb(1'b1, itab_pkg::OFS_BRK_CTRL, 32'h0);
    pf(ba);
    rdc("brk_noset", itab_pkg::OFS_BRK_CTRL, 32'h0);
    $display("test break done");
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, itab_pkg::OFS_SYS_CTRL, m ? 32'h21 : 32'h01);
      for (int n = 0; n < 4; n++) begin
        seed = lfsr(seed);
        cpu.condition_code_register <= seed[31:24];
        entry(1'b1, 2'(n), itab_pkg::VEC_TRAP_BASE + 8'(n), 1'(m));
      end
    end
    $display("test trap done");
    cpu.condition_code_register <= 8'h80;
    for (int e = 1; e >= 0; e--) begin
      apb(1'b1, itab_pkg::OFS_SYS_CTRL, 32'(e));
      for (int v = 0; v < 2; v++) begin
        nmi <= 1'(v);
        look("nmi_pend", v == e);
        if (v == e) entry(1'b0, 2'h0, itab_pkg::VEC_NMI, 1'b0);
      end
    end
    $display("test nmi done");
    cpu.condition_code_register <= 8'h00;
    seed = lfsr(seed);
    k = seed[2:0];
    sa = seed[3];
    apb(1'b1, itab_pkg::OFS_PORT_SEL, {24'h0, 8'(seed[3]) << k});
    drv(1'b0);
    look("pin_masked", 1'b0);
    apb(1'b1, itab_pkg::OFS_PIN_EN, {24'h0, 8'h01 << k});
    look("pin_level", 1'b1);
    entry(1'b0, 2'h0, itab_pkg::VEC_PIN_BASE + 8'(k), 1'b0);
    drv(1'b1);
    look("pin_idle", 1'b0);
    for (int c = 1; c < 4; c++) begin
      seed = lfsr(seed);
      k = seed[2:0];
      sa = seed[3];
      apb(1'b1, itab_pkg::OFS_PORT_SEL, {24'h0, 8'(seed[3]) << k});
      apb(1'b1, k[2] ? itab_pkg::OFS_SENSE_HI : itab_pkg::OFS_SENSE_LO,
        32'(c) << (2 * k[1:0]));
      apb(1'b1, itab_pkg::OFS_PIN_EN, {24'h0, 8'h01 << k});
      for (int v = 0; v < 2; v++) begin
        drv(1'(v));
        look("pin_edge", v ? c[1] : c != 2);
        if (v ? c[1] : c != 2) entry(1'b0, 2'h0, itab_pkg::VEC_PIN_BASE + 8'(k), 1'b0);
      end
    end
    apb(1'b1, itab_pkg::OFS_PIN_EN, 32'h0);
    $display("test pins done");
    preq <= 8'h11;
    entry(1'b0, 2'h0, itab_pkg::VEC_PERIPH_BASE, 1'b0);
    apb(1'b1, itab_pkg::OFS_LVL_B, 32'h08);
    entry(1'b0, 2'h0, itab_pkg::VEC_PERIPH_BASE + 8'h04, 1'b0);
    apb(1'b1, itab_pkg::OFS_SYS_CTRL, 32'h0);
    nmi <= 1'b0;
    entry(1'b0, 2'h0, itab_pkg::VEC_NMI, 1'b0);
    $display("test priority done");
    end_of_test();
  end
endmodule : tb_intc_trap_address_break
`default_nettype wire
